//--- scsi_bus_model.sv
// behavioural initiator and target pair driving the observed lines
`timescale 1ns/10ps
`include "scsi_filter_map.svh"
module scsi_bus_model (
  input  wire logic        hclk,
  output logic [8:0]       ctrl,
  output logic [15:0]      data,
  output logic [1:0]       parity,
  output logic [3:0]       probes
);
  logic [8:0]  c;
  logic [15:0] d;
  int          gap;
  initial begin
    {probes, parity, data, ctrl} = '0;
    c = 9'h000;
    d = 16'h0000;
    gap = 3;
  end
  task put(input logic [`LN_W-1:0] v);
    @(posedge hclk);
    {probes, parity, data, ctrl} <= v;
  endtask
  // released lines fall to the terminated, deasserted level
  task step;
    put({4'h0, (d != 16'h0) ? {~^d[15:8], ~^d[7:0]} : 2'b00, d, c});
    repeat (gap) @(posedge hclk);
  endtask
  task select(input int i, input int t);
    c = 9'h100;
    d = 16'h1 << i;
    step;
    c = 9'h180;
    step;
    c = 9'h080;
    d = (16'h1 << i) | (16'h1 << t);
    step;
    c = 9'h180;
    step;
    c = 9'h100;
    d = 16'h0000;
    step;
  endtask
  task phase(input logic io);
    c[`LN_IO] = io;
    step;
  endtask
  // data is stable before the qualifying edge and held past both rises
  task transfer(input logic [15:0] w);
    d = w;
    step;
    c[`LN_REQ] = 1'b1;
    step;
    c[`LN_ACK] = 1'b1;
    step;
    c[`LN_REQ] = 1'b0;
    step;
    c[`LN_ACK] = 1'b0;
    step;
    d = 16'h0000;
    step;
  endtask
  task free;
    c = 9'h000;
    d = 16'h0000;
    step;
  endtask
endmodule

//--- scsi_capture_event_filter.sv
// front-end event filter and id qualifier of the scsi capture path
`timescale 1ns/10ps
`include "scsi_filter_map.svh"
module scsi_capture_event_filter (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic [8:0]        scsi_ctrl,
  input  wire logic [15:0]       scsi_data,
  input  wire logic [1:0]        scsi_parity,
  input  wire logic [3:0]        external_probe_inputs,
  output logic                   event_valid,
  output logic [31:0]            event_time,
  output logic [`LN_W-1:0]       event_lines,
  output logic                   acq_valid,
  output logic                   phase_trigger,
  output scsi_filter_pkg::conn_state_e bus_state
);
  import scsi_filter_pkg::*;

  // configuration and bus slave state
  logic [31:0]           ctrl;
  logic [31:0]           next_ctrl;
  logic                  ap_valid;
  logic                  next_ap_valid;
  logic                  ap_write;
  logic                  next_ap_write;
  logic [`SF_ADDR_W-1:0] ap_addr;
  logic [`SF_ADDR_W-1:0] next_ap_addr;
  logic [31:0]           next_hrdata;

  // capture state
  logic [`LN_W-1:0]      cur;
  logic [`LN_W-1:0]      prev;
  logic                  run_d;
  logic                  next_run_d;
  logic [3:0]            ts_div;
  logic [3:0]            next_ts_div;
  logic [31:0]           ts;
  logic [31:0]           next_ts;
  logic [31:0]           ev_count;
  logic [31:0]           next_ev_count;
  logic                  next_event_valid;
  logic [31:0]           next_event_time;
  logic [`LN_W-1:0]      next_event_lines;
  logic                  next_acq_valid;
  logic                  next_phase_trigger;
  conn_state_e           next_bus_state;

  // decoded configuration and per-sample terms
  logic                  run;
  logic                  wide;
  filter_mode_e          fmode;
  id_opt_e               iopt;
  logic [3:0]            psel;
  logic [`LN_W-1:0]      changed;
  logic [`LN_W-1:0]      eff;
  logic                  hit;
  logic                  asp;
  logic                  pair_ok;
  logic                  id_pass;
  logic                  run_start;
  logic                  addr_take;
  conn_state_e           trk_state;
  scsi_id_t              trk_init;
  scsi_id_t              trk_tgt;

  scsi_line_sync u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .raw     ({external_probe_inputs, scsi_parity, scsi_data, scsi_ctrl}),
    .synced  (cur)
  );

  scsi_conn_tracker u_trk (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ctrl    (cur[8:0]),
    .ids     (cur[`LN_D_LO +: 8]),
    .state   (trk_state),
    .init_id (trk_init),
    .tgt_id  (trk_tgt)
  );

  // phase table on control lines; ack/req "p" columns need a rising edge
  function automatic logic phase_match(input logic [3:0] code,
                                       input logic [8:0] c,
                                       input logic       req_up,
                                       input logic       ack_up);
    logic base;
    base = c[`LN_BSY] && !c[`LN_SEL] && !c[`LN_RST];
    case (code)
      `PH_ARB:      phase_match = (c & ~(9'h1 << `LN_ATN)) == `CT_ARB
                                  && !c[`LN_ATN];
      `PH_SEL:      phase_match = !c[`LN_BSY] && c[`LN_SEL]
                                  && !c[`LN_IO] && !c[`LN_RST];
      `PH_RESEL:    phase_match = !c[`LN_BSY] && c[`LN_SEL]
                                  && c[`LN_IO] && !c[`LN_RST];
      `PH_MSG_OUT:  phase_match = base && !c[`LN_REQ] && ack_up
                                  && c[`LN_CD] && !c[`LN_IO] && c[`LN_MSG];
      `PH_CMD:      phase_match = base && !c[`LN_REQ] && ack_up
                                  && c[`LN_CD] && !c[`LN_IO] && !c[`LN_MSG];
      `PH_DATA_OUT: phase_match = base && (req_up || ack_up)
                                  && !c[`LN_CD] && !c[`LN_IO] && !c[`LN_MSG];
      `PH_DATA_IN:  phase_match = base && (req_up || ack_up)
                                  && !c[`LN_CD] && c[`LN_IO] && !c[`LN_MSG];
      `PH_STATUS:   phase_match = base && req_up && !c[`LN_ACK]
                                  && c[`LN_CD] && c[`LN_IO] && !c[`LN_MSG];
      `PH_MSG_IN:   phase_match = base && req_up && !c[`LN_ACK]
                                  && c[`LN_CD] && c[`LN_IO] && c[`LN_MSG];
      default:      phase_match = 1'b0;
    endcase
  endfunction

  // register read decode
  function automatic logic [31:0] read_reg(input logic [`SF_ADDR_W-1:0] a,
                                           input logic [31:0] c,
                                           input logic [31:0] st,
                                           input logic [31:0] cnt,
                                           input logic [31:0] t);
    if (a == `SF_OFS_CTRL) begin
      read_reg = c;
    end else if (a == `SF_OFS_STATUS) begin
      read_reg = st;
    end else if (a == `SF_OFS_EVCOUNT) begin
      read_reg = cnt;
    end else if (a == `SF_OFS_TSTAMP) begin
      read_reg = t;
    end else begin
      read_reg = 32'h0000_0000;
    end
  endfunction

  // bus slave: zero wait states, read data registered for the data phase
  always_comb begin
    logic [31:0] status;
    status = 32'h0000_0000;
    status[`SF_ST_RUN] = ctrl[`SF_RUN];
    status[`SF_ST_STATE_LO +: 2] = trk_state;
    status[`SF_ST_INIT_LO +: 3] = trk_init;
    status[`SF_ST_TGT_LO +: 3] = trk_tgt;
    addr_take     = hsel && htrans[1] && hready;
    next_ap_valid = addr_take;
    next_ap_write = addr_take && hwrite;
    next_ap_addr  = addr_take ? haddr[`SF_ADDR_W-1:0] : ap_addr;
    next_hrdata   = hrdata;
    if (addr_take && !hwrite) begin
      next_hrdata = read_reg(haddr[`SF_ADDR_W-1:0], ctrl, status,
                             ev_count, ts);
    end
    next_ctrl = ctrl;
    if (ap_valid && ap_write && (ap_addr == `SF_OFS_CTRL)) begin
      if (ctrl[`SF_RUN]) begin
        // while running only the run bit may change
        next_ctrl[`SF_RUN] = hwdata[`SF_RUN];
      end else begin
        next_ctrl = hwdata & `SF_CTRL_MASK;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl      <= `SF_CTRL_RESET;
      ap_valid  <= 1'b0;
      ap_write  <= 1'b0;
      ap_addr   <= '0;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      ctrl      <= next_ctrl;
      ap_valid  <= next_ap_valid;
      ap_write  <= next_ap_write;
      ap_addr   <= next_ap_addr;
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // event creation, filtering, id qualification and time stamping
  always_comb begin
    logic req_up;
    logic ack_up;
    req_up    = !prev[`LN_REQ] && cur[`LN_REQ];
    ack_up    = !prev[`LN_ACK] && cur[`LN_ACK];
    run       = ctrl[`SF_RUN];
    wide      = ctrl[`SF_WIDE];
    fmode     = filter_mode_e'(ctrl[`SF_FMODE_LO +: 2]);
    iopt      = id_opt_e'(ctrl[`SF_IOPT_LO +: 2]);
    psel      = ctrl[`SF_PSEL_LO +: 4];
    run_start = run && !run_d;
    changed   = cur ^ prev;
    // narrow bus: upper data and dp1 changes do not count
    eff = wide ? changed : (changed & ~`LN_UPPER_MASK);
    case (fmode)
      FILT_OFF:  hit = |eff;
      FILT_FOUR: hit = |(eff & (`LN_CTRL_MASK | `LN_EXT_MASK));
      FILT_ONE:  hit = |(eff & `LN_ONE_MASK)
                       || (req_up && cur[`LN_IO])
                       || (ack_up && !cur[`LN_IO]);
      default:   hit = 1'b0;
    endcase
    asp     = (trk_state != CONN_INFO);
    pair_ok = (ctrl[`SF_INIT_ANY] || trk_init == ctrl[`SF_INIT_LO +: 3])
              && (ctrl[`SF_TGT_ANY] || trk_tgt == ctrl[`SF_TGT_LO +: 3]);
    case (iopt)
      ID_OFF:      id_pass = 1'b1;
      ID_ALLOW:    id_pass = asp || pair_ok;
      ID_SUPPRESS: id_pass = !asp && pair_ok;
      default:     id_pass = 1'b1;
    endcase
    next_run_d  = run;
    next_ts_div = ts_div;
    next_ts     = ts;
    if (!run || run_start) begin
      next_ts_div = 4'h0;
      next_ts     = 32'h0000_0000;
    end else if (ts_div == `TS_DIV_LAST) begin
      next_ts_div = 4'h0;
      next_ts     = ts + 32'h0000_0001;
    end else begin
      next_ts_div = ts_div + 4'h1;
    end
    next_event_valid   = run && hit;
    next_event_time    = hit ? ts : event_time;
    next_event_lines   = hit ? cur : event_lines;
    next_acq_valid     = run && hit && id_pass;
    // info phase triggers are dead in one-event mode
    next_phase_trigger = run && hit && ctrl[`SF_PTRIG_EN]
                         && phase_match(psel, cur[8:0], req_up, ack_up)
                         && !(fmode == FILT_ONE
                              && psel >= `PH_FIRST_INFO);
    next_ev_count = ev_count;
    if (run_start) begin
      next_ev_count = 32'h0000_0000;
    end else if (next_acq_valid) begin
      next_ev_count = ev_count + 32'h0000_0001;
    end
    next_bus_state = trk_state;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev          <= '0;
      run_d         <= 1'b0;
      ts_div        <= 4'h0;
      ts            <= 32'h0000_0000;
      ev_count      <= 32'h0000_0000;
      event_valid   <= 1'b0;
      event_time    <= 32'h0000_0000;
      event_lines   <= '0;
      acq_valid     <= 1'b0;
      phase_trigger <= 1'b0;
      bus_state     <= CONN_FREE;
    end else begin
      prev          <= cur;
      run_d         <= next_run_d;
      ts_div        <= next_ts_div;
      ts            <= next_ts;
      ev_count      <= next_ev_count;
      event_valid   <= next_event_valid;
      event_time    <= next_event_time;
      event_lines   <= next_event_lines;
      acq_valid     <= next_acq_valid;
      phase_trigger <= next_phase_trigger;
      bus_state     <= next_bus_state;
    end
  end
endmodule

//--- scsi_conn_tracker.sv
// follows arbitration and selection to learn the connected id pair
`timescale 1ns/10ps
`include "scsi_filter_map.svh"
module scsi_conn_tracker (
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  input  wire logic [8:0]                  ctrl,
  input  wire logic [7:0]                  ids,
  output scsi_filter_pkg::conn_state_e     state,
  output scsi_filter_pkg::scsi_id_t        init_id,
  output scsi_filter_pkg::scsi_id_t        tgt_id
);
  import scsi_filter_pkg::*;

  conn_state_e next_state;
  scsi_id_t    owner;
  scsi_id_t    next_owner;
  scsi_id_t    next_init_id;
  scsi_id_t    next_tgt_id;
  logic        bsy;
  logic        sel;
  logic [7:0]  others;

  // arbitration goes to the highest id on the bus
  function automatic scsi_id_t top_id(input logic [7:0] v);
    scsi_id_t r;
    r = 3'h0;
    for (int k = 0; k < 8; k++) begin
      if (v[k]) begin
        r = 3'(k);
      end
    end
    return r;
  endfunction

  always_comb begin
    bsy          = ctrl[`LN_BSY];
    sel          = ctrl[`LN_SEL];
    others       = ids & ~(8'h01 << owner);
    next_state   = state;
    next_owner   = owner;
    next_init_id = init_id;
    next_tgt_id  = tgt_id;
    case (state)
      CONN_FREE: begin
        if (bsy && !sel) begin
          next_state = CONN_ARB;
          next_owner = top_id(ids);
        end else if (sel && !bsy) begin
          next_state = CONN_SELECT;
        end
      end
      CONN_ARB: begin
        if (bsy && !sel) begin
          next_owner = top_id(ids);
        end else if (sel) begin
          next_state = CONN_SELECT;
        end else begin
          next_state = CONN_FREE;
        end
      end
      CONN_SELECT: begin
        // with i/o low the owner selects a target, high it reselects
        if (sel && !bsy && (others != 8'h00)) begin
          if (ctrl[`LN_IO]) begin
            next_tgt_id  = owner;
            next_init_id = top_id(others);
          end else begin
            next_init_id = owner;
            next_tgt_id  = top_id(others);
          end
        end
        if (bsy && !sel) begin
          next_state = CONN_INFO;
        end else if (!bsy && !sel) begin
          next_state = CONN_FREE;
        end
      end
      CONN_INFO: begin
        if (!bsy) begin
          next_state = CONN_FREE;
        end
      end
      default: begin
        next_state = CONN_FREE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state   <= CONN_FREE;
      owner   <= 3'h0;
      init_id <= 3'h0;
      tgt_id  <= 3'h0;
    end else begin
      state   <= next_state;
      owner   <= next_owner;
      init_id <= next_init_id;
      tgt_id  <= next_tgt_id;
    end
  end
endmodule

//--- scsi_filter_asserts.sv
// port-level assertion checker for the scsi capture event filter
`timescale 1ns/10ps
`include "scsi_filter_map.svh"
module scsi_filter_asserts (
  input wire logic             hclk,
  input wire logic             hresetn,
  input wire logic             hsel,
  input wire logic [31:0]      haddr,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic             hready,
  input wire logic [31:0]      hrdata,
  input wire logic             hreadyout,
  input wire logic             hresp,
  input wire logic [8:0]       scsi_ctrl,
  input wire logic [15:0]      scsi_data,
  input wire logic [1:0]       scsi_parity,
  input wire logic [3:0]       external_probe_inputs,
  input wire logic             event_valid,
  input wire logic [31:0]      event_time,
  input wire logic [`LN_W-1:0] event_lines,
  input wire logic             acq_valid,
  input wire logic             phase_trigger
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic [`LN_W-1:0] ln;
  logic             rd_take;
  assign ln = {external_probe_inputs, scsi_parity, scsi_data, scsi_ctrl};
  assign rd_take = hsel && htrans[1] && hready && !hwrite;
  a_ready_high: assert property (hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  a_acq_in_event: assert property (acq_valid |-> event_valid)
    else $error("acq pulse without event");
  a_trig_in_event: assert property (phase_trigger |-> event_valid)
    else $error("trigger without event");
  // lines need two sync edges plus one to compare, so a cause is 3 back
  a_event_cause: assert property (
    event_valid |-> $past(ln, 3) != $past(ln, 4))
    else $error("event with no line change");
  a_lines_snap: assert property (
    event_valid |-> event_lines == $past(ln, 3))
    else $error("event snapshot wrong");
  a_stamp_step: assert property (
    event_valid && $past(event_valid) |->
      event_time - $past(event_time) <= 32'h1)
    else $error("stamp moved too fast");
  a_unmapped_zero: assert property (
    rd_take && haddr[11:0] > `SF_OFS_TSTAMP |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_ctrl_bits: assert property (
    rd_take && haddr[11:0] == `SF_OFS_CTRL |=>
      (hrdata & ~`SF_CTRL_MASK) == 32'h0)
    else $error("ctrl unused bits set");
  c_acq: cover property (acq_valid);
  c_trig: cover property (phase_trigger);
  c_b2b: cover property (event_valid ##1 event_valid);
endmodule

//--- scsi_filter_map.svh
// constant map for the scsi capture event filter
`ifndef SCSI_FILTER_MAP_SVH
`define SCSI_FILTER_MAP_SVH

// register byte offsets, compared on the low address bits
`define SF_ADDR_W       12
`define SF_OFS_CTRL     12'h000
`define SF_OFS_STATUS   12'h004
`define SF_OFS_EVCOUNT  12'h008
`define SF_OFS_TSTAMP   12'h00C

// control register fields
`define SF_RUN          0
`define SF_WIDE         1
`define SF_FMODE_LO     2
`define SF_IOPT_LO      4
`define SF_INIT_LO      8
`define SF_INIT_ANY     11
`define SF_TGT_LO       12
`define SF_TGT_ANY      15
`define SF_PSEL_LO      16
`define SF_PTRIG_EN     20
`define SF_CTRL_MASK    32'h001F_FF3F
`define SF_CTRL_RESET   32'h0000_0000

// status register fields
`define SF_ST_RUN       0
`define SF_ST_STATE_LO  1
`define SF_ST_INIT_LO   4
`define SF_ST_TGT_LO    8

// sampled line vector layout
`define LN_W            31
`define LN_RST          0
`define LN_MSG          1
`define LN_IO           2
`define LN_CD           3
`define LN_ACK          4
`define LN_REQ          5
`define LN_ATN          6
`define LN_SEL          7
`define LN_BSY          8
`define LN_D_LO         9
`define LN_DP_LO        25
`define LN_EXT_LO       27
`define LN_UPPER_MASK   31'h05FE_0000
`define LN_CTRL_MASK    31'h0000_01FF
`define LN_EXT_MASK     31'h7800_0000
`define LN_ONE_MASK     31'h7800_01CF

// control line patterns, bsy in the top bit
`define CT_ARB          9'h100

// phase trigger codes
`define PH_ARB          4'h0
`define PH_SEL          4'h1
`define PH_RESEL        4'h2
`define PH_MSG_OUT      4'h3
`define PH_CMD          4'h4
`define PH_DATA_OUT     4'h5
`define PH_DATA_IN      4'h6
`define PH_STATUS       4'h7
`define PH_MSG_IN       4'h8
`define PH_FIRST_INFO   4'h3

// time stamp resolution
`define TS_RES_NS       20
`define CLK_NS          10
`define TS_DIV          ((`TS_RES_NS + `CLK_NS - 1) / `CLK_NS)
`define TS_DIV_LAST     4'((`TS_DIV) - 1)

`endif

//--- scsi_filter_pkg.sv
// types shared by the scsi capture event filter
package scsi_filter_pkg;

  typedef enum logic [1:0] {
    CONN_FREE   = 2'b00,
    CONN_ARB    = 2'b01,
    CONN_SELECT = 2'b11,
    CONN_INFO   = 2'b10
  } conn_state_e;

  typedef enum logic [1:0] {
    FILT_OFF  = 2'b00,
    FILT_FOUR = 2'b01,
    FILT_ONE  = 2'b11
  } filter_mode_e;

  typedef enum logic [1:0] {
    ID_OFF      = 2'b00,
    ID_ALLOW    = 2'b01,
    ID_SUPPRESS = 2'b11
  } id_opt_e;

  typedef logic [2:0] scsi_id_t;

endpackage

//--- scsi_line_sync.sv
// two-stage synchroniser for the observed bus and probe lines
`timescale 1ns/10ps
`include "scsi_filter_map.svh"
module scsi_line_sync (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [`LN_W-1:0] raw,
  output logic      [`LN_W-1:0] synced
);
  logic [`LN_W-1:0] meta;

  genvar i;
  generate
    for (i = 0; i < `LN_W; i = i + 1) begin : g_bit
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          meta[i]   <= 1'b0;
          synced[i] <= 1'b0;
        end else begin
          meta[i]   <= raw[i];
          synced[i] <= meta[i];
        end
      end
    end
  endgenerate
endmodule

//--- testbench.sv
// self-checking testbench for the scsi capture event filter
`timescale 1ns/10ps
`include "scsi_filter_map.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module testbench;
  import scsi_filter_pkg::*;
  logic             hclk = 1'b0;
  logic             hresetn = 1'b0;
  logic             hsel = 1'b0;
  logic             hwrite = 1'b0;
  logic [1:0]       htrans = 2'b00;
  logic [31:0]      haddr = 32'h0;
  logic [31:0]      hwdata = 32'h0;
  logic [31:0]      hrdata, event_time, rd, t_last, t_prev;
  logic             hready, hreadyout, hresp;
  logic             event_valid, acq_valid, phase_trigger;
  logic [8:0]       scsi_ctrl;
  logic [15:0]      scsi_data;
  logic [1:0]       scsi_parity;
  logic [3:0]       probes;
  logic [`LN_W-1:0] event_lines, l_last, cur, nv;
  conn_state_e      bus_state;
  logic [15:0]      seed = 16'h5FAC;
  logic [15:0]      dw;
  logic [1:0]       m;
  logic             w;
  int               fail_count, checks, ev_n, acq_n, trg_n;
  int               e0, a0, g0, ar, exp_n;
  assign hready = hreadyout;
  always #5 hclk = ~hclk;
  scsi_capture_event_filter dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .scsi_ctrl(scsi_ctrl), .scsi_data(scsi_data),
    .scsi_parity(scsi_parity), .external_probe_inputs(probes),
    .event_valid(event_valid), .event_time(event_time),
    .event_lines(event_lines), .acq_valid(acq_valid),
    .phase_trigger(phase_trigger), .bus_state(bus_state));
  scsi_bus_model bus (.hclk(hclk), .ctrl(scsi_ctrl), .data(scsi_data),
    .parity(scsi_parity), .probes(probes));
  always @(posedge hclk) begin
    if (event_valid === 1'b1) begin
      ev_n++;
      t_prev = t_last;
      t_last = event_time;
      l_last = event_lines;
    end
    if (acq_valid === 1'b1) acq_n++;
    if (phase_trigger === 1'b1) trg_n++;
  end
  function automatic int rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return int'(seed);
  endfunction
  function automatic logic [31:0] mk(input logic [1:0] fm,
    input logic [1:0] o, input logic [2:0] i, input logic [2:0] t);
    return (32'(fm) << `SF_FMODE_LO) | (32'(o) << `SF_IOPT_LO) |
      (32'(i) << `SF_INIT_LO) | (32'(t) << `SF_TGT_LO) | 32'h2;
  endfunction
  function automatic int exp_ev(input logic [1:0] fm, input logic wd,
    input logic [`LN_W-1:0] a, input logic [`LN_W-1:0] b);
    logic [`LN_W-1:0] d;
    d = a ^ b;
    if (!wd) d = d & ~`LN_UPPER_MASK;
    case (fm)
      FILT_OFF: return int'(d != 0);
      FILT_FOUR: return int'((d & (`LN_CTRL_MASK | `LN_EXT_MASK)) != 0);
      FILT_ONE: return int'((d & `LN_ONE_MASK) != 0 ||
        (b[`LN_REQ] && !a[`LN_REQ] && b[`LN_IO]) ||
        (b[`LN_ACK] && !a[`LN_ACK] && !b[`LN_IO]));
      default: return 0;
    endcase
  endfunction
  task ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {20'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // an event is counted four edges after its pin change, so let it land
  task settle;
    repeat (4) @(posedge hclk);
  endtask
  task snap;
    settle;
    e0 = ev_n;
    a0 = acq_n;
    g0 = trg_n;
  endtask
  // settings only take while stopped, so stop, load, then start
  task cfg(input logic [31:0] v);
    ahb(1'b1, `SF_OFS_CTRL, 32'h0);
    ahb(1'b1, `SF_OFS_CTRL, v);
    ahb(1'b1, `SF_OFS_CTRL, v | 32'h1);
    snap;
    ar = acq_n;
  endtask
  task complete_run;
    $display("checks %0d errors %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    complete_run;
  end
  initial begin
    cur = '0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    `CHK(hreadyout, 1'b1)
    `CHK(hresp, 1'b0)
    ahb(1'b0, `SF_OFS_CTRL, 32'h0);
    `CHK(rd, `SF_CTRL_RESET)
    ahb(1'b1, `SF_OFS_CTRL, 32'hFFFF_FFFE);
    ahb(1'b0, `SF_OFS_CTRL, 32'h0);
    `CHK(rd, `SF_CTRL_MASK & 32'hFFFF_FFFE)
    ahb(1'b1, 12'h010, 32'hFFFF_FFFF);
    ahb(1'b0, 12'h010, 32'h0);
    `CHK(rd, 32'h0)
    for (int r = 0; r < 6; r++) begin
      m = (r == 0) ? 2'b00 : 2'(rnd());
      w = (r == 0) ? 1'b0 : 1'(rnd());
      cfg((mk(m, ID_OFF, 3'h0, 3'h0) & ~32'h2) | {30'h0, w, 1'b0});
      exp_n = 0;
      for (int k = 0; k < 10; k++) begin
        nv = cur ^ (31'h1 << ((r == 0 && k < 2) ? 17 + 9 * k : rnd() % 31));
        bus.put(nv);
        repeat (5) @(posedge hclk);
        exp_n += exp_ev(m, w, cur, nv);
        `CHK(ev_n - e0, exp_n)
        `CHK(acq_n - a0, ev_n - e0)
        cur = nv;
      end
    end
    cfg(mk(FILT_OFF, ID_OFF, 3'h0, 3'h0));
    ahb(1'b1, `SF_OFS_CTRL, 32'h1);
    ahb(1'b0, `SF_OFS_CTRL, 32'h0);
    `CHK(rd, 32'h3)
    bus.put(cur ^ 31'h200);
    repeat (9) @(posedge hclk);
    bus.put(cur);
    repeat (5) @(posedge hclk);
    `CHK(ev_n - e0, 2)
    `CHK(t_last - t_prev, 32'h5)
    bus.put('0);
    repeat (6) @(posedge hclk);
    cfg(mk(FILT_ONE, ID_SUPPRESS, 3'h7, 3'h2) | 32'h0016_0000);
    bus.select(7, 2);
    settle;
    `CHK(acq_n - a0, 0)
    bus.phase(1'b1);
    snap;
    for (int k = 0; k < 3; k++) begin
      dw = 16'(rnd());
      bus.transfer(dw);
      `CHK(l_last[24:9], dw)
    end
    `CHK(ev_n - e0, 3)
    `CHK(acq_n - a0, 3)
    `CHK(trg_n - g0, 0)
    `CHK(bus_state, CONN_INFO)
    ahb(1'b0, `SF_OFS_EVCOUNT, 32'h0);
    `CHK(rd, 32'(acq_n - ar))
    bus.free;
    bus.gap = 1;
    cfg(mk(FILT_ONE, ID_ALLOW, 3'h3, 3'h4) | 32'h0010_0000);
    bus.select(7, 2);
    settle;
    `CHK(acq_n - a0, ev_n - e0)
    `CHK(int'(trg_n > g0), 1)
    bus.phase(1'b0);
    snap;
    bus.transfer(16'(rnd()));
    bus.transfer(16'(rnd()));
    `CHK(ev_n - e0, 2)
    `CHK(acq_n - a0, 0)
    bus.free;
    cfg(mk(FILT_FOUR, ID_SUPPRESS, 3'h0, 3'h0) | 32'h0000_8800);
    bus.select(5, 1);
    bus.phase(1'b1);
    snap;
    bus.transfer(16'(rnd()));
    settle;
    `CHK(ev_n - e0, 4)
    `CHK(acq_n - a0, 4)
    bus.free;
    complete_run;
  end
endmodule
bind scsi_capture_event_filter scsi_filter_asserts u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .scsi_ctrl(scsi_ctrl),
  .scsi_data(scsi_data), .scsi_parity(scsi_parity),
  .external_probe_inputs(external_probe_inputs),
  .event_valid(event_valid), .event_time(event_time),
  .event_lines(event_lines), .acq_valid(acq_valid),
  .phase_trigger(phase_trigger));
